// >>> common/mad_pkg.sv
// Purpose: constants and types for the mode-dependent address map decoder
// Assumes: 24-bit advanced addresses, 16-bit normal-mode addresses in the low bits
// Notes: boundaries follow the largest-ROM family member; smaller ROM is a parameter
package mad_pkg;
	localparam int ADDR_W = 24;
	localparam logic [23:0] NORMAL_SPACE_MASK = 24'h00ffff;
	localparam logic [23:0] ADV_SPACE_MASK = 24'hffffff;
	localparam logic [23:0] ROM_MAX_NORMAL = 24'h00e000;
	localparam logic [23:0] ROM_2ND_BASE = 24'h010000;
	localparam logic [23:0] ROM_2ND_END = 24'h01ffff;
	localparam logic [23:0] ROM_SIZE_DEFAULT = 24'h020000;
	localparam logic [23:0] ADV_RSV_BASE = 24'hffdc00;
	localparam logic [23:0] ADV_RAM_BASE = 24'hffdc00;
	localparam logic [23:0] ADV_RAM_END = 24'hfffbff;
	localparam logic [23:0] ADV_IO1_BASE = 24'hfffc00;
	localparam logic [23:0] ADV_IO1_END = 24'hfffe3f;
	localparam logic [23:0] ADV_IO2_BASE = 24'hffff28;
	localparam logic [15:0] NRM_RAM_BASE = 16'hec00;
	localparam logic [15:0] NRM_RAM_END = 16'hfbff;
	localparam logic [15:0] NRM_IO1_BASE = 16'hfc00;
	localparam logic [15:0] NRM_IO1_END = 16'hfe3f;
	localparam logic [15:0] NRM_IO2_BASE = 16'hff28;
	localparam logic [2:0] AREA_MSB = 3'h7;
	localparam int AREA_SHIFT = 21;
	localparam logic [2:0] MODE_MIN = 3'h1;
	localparam logic [2:0] MODE_ADV_FIRST = 3'h4;
	typedef enum logic [2:0] {
		MAD_TGT_NONE = 3'h0,
		MAD_TGT_ROM = 3'h1,
		MAD_TGT_RAM = 3'h3,
		MAD_TGT_IO = 3'h2,
		MAD_TGT_EXT = 3'h6,
		MAD_TGT_RSV = 3'h7
	} mad_target_type;
endpackage

// >>> common/mad_req_if.sv
`timescale 1ns/1ns
// Purpose: carries one decode request and its answer between main and leaf
// Assumes: single clock; answer is combinational from the leaf
// Notes: none
interface mad_req_if;
	import mad_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic [2:0] mode;
	logic ram_en;
	logic ext_bit;
	mad_pkg::mad_target_type target;
	logic [2:0] area;
	modport ctrl (output addr, output mode, output ram_en, output ext_bit,
		input target, input area);
	modport dec (input addr, input mode, input ram_en, input ext_bit,
		output target, output area);
endinterface

// >>> rtl/mad_map_logic.sv
`timescale 1ns/1ns
// Purpose: combinational address classification for one access
// Assumes: mode may be 0, which is not legal and selects nothing
// Notes: ROM size is a parameter per family member
module mad_map_logic #(
	parameter logic [23:0] ROM_SIZE = mad_pkg::ROM_SIZE_DEFAULT
) (
	mad_req_if.dec req
);
	import mad_pkg::*;

	// ***********************************
	// range helper
	// ***********************************
	function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
		input logic [23:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	logic adv;
	logic single;
	logic rom_on;
	logic [23:0] a;
	logic [15:0] n;
	logic [23:0] rom_lim;
	logic [23:0] io2_lo;

	// ***********************************
	// classification
	// ***********************************
	always_comb begin
		adv = (req.mode >= MODE_ADV_FIRST);
		single = (req.mode == 3'h3) || (req.mode == 3'h7);
		rom_on = (req.mode == 3'h2) || single || (req.mode == 3'h6);
		a = req.addr & (adv ? ADV_SPACE_MASK : NORMAL_SPACE_MASK);
		n = a[15:0];
		// normal modes never map more than the 56k window
		rom_lim = (!adv && ROM_SIZE > ROM_MAX_NORMAL) ? ROM_MAX_NORMAL : ROM_SIZE;
		io2_lo = adv ? ADV_IO2_BASE : {8'h00, NRM_IO2_BASE};
		req.area = (adv && req.mode != 3'h7) ? a[AREA_SHIFT +: 3] : 3'h0;
		req.target = single ? MAD_TGT_RSV : MAD_TGT_EXT;
		if (a >= io2_lo) begin
			req.target = MAD_TGT_IO;
		end else if (adv) begin
			if (in_rng(a, ADV_IO1_BASE, ADV_IO1_END)) begin
				req.target = MAD_TGT_IO;
			end else if (in_rng(a, ADV_RAM_BASE, ADV_RAM_END)) begin
				if (req.ram_en || single) begin
					req.target = MAD_TGT_RAM;
				end else begin
					req.target = MAD_TGT_EXT;
				end
			end else if (rom_on && in_rng(a, ROM_2ND_BASE, ROM_2ND_END)
				&& a < rom_lim) begin
				if (!req.ext_bit) begin
					req.target = MAD_TGT_ROM;
				end else if (single) begin
					req.target = MAD_TGT_RSV;
				end else begin
					req.target = MAD_TGT_EXT;
				end
			end else if (rom_on && a < rom_lim && a < ROM_2ND_BASE) begin
				req.target = MAD_TGT_ROM;
			end
		end else begin
			if (in_rng({8'h00, n}, {8'h00, NRM_IO1_BASE}, {8'h00, NRM_IO1_END})) begin
				req.target = MAD_TGT_IO;
			end else if (in_rng({8'h00, n}, {8'h00, NRM_RAM_BASE}, {8'h00, NRM_RAM_END}))
				begin
				req.target = (req.ram_en || single) ? MAD_TGT_RAM : MAD_TGT_EXT;
			end else if (rom_on && {8'h00, n} < rom_lim) begin
				req.target = MAD_TGT_ROM;
			end
		end
		if (req.mode < MODE_MIN) begin
			req.target = MAD_TGT_NONE;
		end
	end
endmodule

// >>> rtl/mad_decoder.sv
`timescale 1ns/1ns
// Purpose: registered mode-dependent address decoder for cpu accesses
// Assumes: mode pins are static straps, sampled after reset release
// Notes: one access per cycle, answer one cycle after the request

// Notes on behaviour
// - 64k space modes 1-3, 16M modes 4-7
// - rom size is a per-variant parameter
// - normal rom modes map at most 56k
// - modes 4-6 report one of eight areas
// - ram disabled routes ram range external, except in single-chip modes 3 and 7
// - mode 6 second rom region external when set
// - mode 7 second region reserved when set
// - ram enable resets to one, kept in standby
// - single-chip modes never reach external space
module mad_decoder #(
	parameter logic [23:0] ROM_SIZE = mad_pkg::ROM_SIZE_DEFAULT
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [2:0] mode_pins_in,
	input wire logic req_valid_in,
	input wire logic [mad_pkg::ADDR_W-1:0] req_addr_in,
	input wire logic ram_enable_wr_in,
	input wire logic ram_enable_data_in,
	input wire logic ext_area_wr_in,
	input wire logic ext_area_data_in,
	output logic ack_valid_out,
	output mad_pkg::mad_target_type target_out,
	output logic [2:0] area_out,
	output logic [2:0] mode_out,
	output logic onchip_ram_enable_bit_out,
	output logic external_area_extend_bit_out
);
	import mad_pkg::*;

	typedef struct packed {
		logic [2:0] pin_s1;
		logic [2:0] pin_s2;
		logic [2:0] mode;
		logic ram_en;
		logic ext_bit;
		logic ack;
		mad_target_type target;
		logic [2:0] area;
	} mad_state_type;

	mad_state_type st_q;
	mad_state_type st_d;

	mad_req_if req();

	// ***********************************
	// decode leaf
	// ***********************************
	assign req.addr = req_addr_in;
	assign req.mode = st_q.mode;
	assign req.ram_en = st_q.ram_en;
	assign req.ext_bit = st_q.ext_bit;

	mad_map_logic #(.ROM_SIZE(ROM_SIZE)) u_map (
		.req(req)
	);

	// ***********************************
	// next state
	// ***********************************
	always_comb begin
		st_d = st_q;
		st_d.pin_s1 = mode_pins_in;
		st_d.pin_s2 = st_q.pin_s1;
		// straps follow the pins only after the synchroniser settles
		st_d.mode = st_q.pin_s2;
		if (ram_enable_wr_in) begin
			st_d.ram_en = ram_enable_data_in;
		end
		if (ext_area_wr_in) begin
			st_d.ext_bit = ext_area_data_in;
		end
		st_d.ack = req_valid_in;
		st_d.target = req_valid_in ? req.target : MAD_TGT_NONE;
		st_d.area = req_valid_in ? req.area : 3'h0;
	end

	// ***********************************
	// registers
	// ***********************************
	// standby is not a reset, so the ram enable simply holds there
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_q <= '0;
			st_q.ram_en <= 1'b1;
			st_q.target <= MAD_TGT_NONE;
		end else begin
			st_q <= st_d;
		end
	end

	assign ack_valid_out = st_q.ack;
	assign target_out = st_q.target;
	assign area_out = st_q.area;
	assign mode_out = st_q.mode;
	assign onchip_ram_enable_bit_out = st_q.ram_en;
	assign external_area_extend_bit_out = st_q.ext_bit;

	// ***********************************
	// checks
	// ***********************************
	sequence s_req_single;
		req_valid_in && (st_q.mode == 3'h3 || st_q.mode == 3'h7);
	endsequence

	AST_SINGLE_NO_EXT: assert property (@(posedge clk_in) disable iff (rst_in)
		s_req_single |=> target_out != MAD_TGT_EXT)
		else $error("single-chip access went external");
	AST_RAM_RESET: assert property (@(posedge clk_in)
		$fell(rst_in) |-> onchip_ram_enable_bit_out)
		else $error("ram enable not one after reset");
	AST_RAM_OFF_EXT: assert property (@(posedge clk_in) disable iff (rst_in)
		req_valid_in && !st_q.ram_en && st_q.mode == 3'h5 && req_addr_in == ADV_RAM_END
		|=> target_out == MAD_TGT_EXT)
		else $error("disabled ram not routed external");
	AST_MODE6_EXT: assert property (@(posedge clk_in) disable iff (rst_in)
		req_valid_in && st_q.mode == 3'h6 && st_q.ext_bit && req_addr_in == ROM_2ND_BASE
		&& ROM_SIZE > ROM_2ND_BASE |=> target_out == MAD_TGT_EXT)
		else $error("mode 6 second region not external");
	AST_MODE7_RSV: assert property (@(posedge clk_in) disable iff (rst_in)
		req_valid_in && st_q.mode == 3'h7 && req_addr_in == ROM_2ND_END
		|=> target_out == (st_q.ext_bit || ROM_SIZE <= ROM_2ND_BASE ? MAD_TGT_RSV : MAD_TGT_ROM))
		else $error("mode 7 second region wrong");
	AST_ROM_56K: assert property (@(posedge clk_in) disable iff (rst_in)
		req_valid_in && st_q.mode == 3'h2 && req_addr_in[15:0] == ROM_MAX_NORMAL[15:0]
		|=> target_out == MAD_TGT_EXT)
		else $error("normal mode rom beyond 56k");
	AST_AREA: assert property (@(posedge clk_in) disable iff (rst_in)
		req_valid_in && st_q.mode == 3'h4 |=> area_out == $past(req_addr_in[23:21]))
		else $error("area not reported");
	AST_NORMAL_WRAP: assert property (@(posedge clk_in) disable iff (rst_in)
		req_valid_in && st_q.mode == 3'h3 && req_addr_in[15:0] == NRM_IO2_BASE
		|=> target_out == MAD_TGT_IO)
		else $error("normal space not 64k");
	AST_ACK: assert property (@(posedge clk_in) disable iff (rst_in)
		req_valid_in && st_q.mode == 3'h5 && req_addr_in == ADV_IO1_BASE
		|=> ack_valid_out && target_out == MAD_TGT_IO)
		else $error("io window missing");
endmodule

// >>> tb/mad_cpu_model.sv
`timescale 1ns/1ns
// Purpose: cpu core model that issues accesses and control bit writes to the decoder
// Assumes: one access per call, signals change just after a rising edge
// Notes: released address lines show the inverse of the last value, never a stale copy
module mad_cpu_model (
	input wire logic clk_in,
	output logic req_valid_out,
	output logic [23:0] req_addr_out,
	output logic ram_wr_out,
	output logic ram_data_out,
	output logic ext_wr_out,
	output logic ext_data_out
);
	// idle values from time zero
	initial begin
		req_valid_out = 1'b0;
		req_addr_out = 24'h000000;
		ram_wr_out = 1'b0;
		ram_data_out = 1'b1;
		ext_wr_out = 1'b0;
		ext_data_out = 1'b0;
	end

	// one request cycle; the decoder takes it at the following edge
	task automatic access(input logic [23:0] a);
		@(posedge clk_in);
		req_valid_out <= 1'b1;
		req_addr_out <= a;
		@(posedge clk_in);
		req_valid_out <= 1'b0;
		req_addr_out <= ~a;
	endtask

	// strobed write of one control bit; data is inverted afterwards so stale data cannot pass
	task automatic write_ctl(input logic sel_ext, input logic v);
		@(posedge clk_in);
		if (sel_ext) begin
			ext_wr_out <= 1'b1;
			ext_data_out <= v;
		end else begin
			ram_wr_out <= 1'b1;
			ram_data_out <= v;
		end
		@(posedge clk_in);
		ext_wr_out <= 1'b0;
		ram_wr_out <= 1'b0;
		ext_data_out <= ~v;
		ram_data_out <= ~v;
	endtask
endmodule

// >>> tb/mad_decoder_tb.sv
`timescale 1ns/1ns
// Purpose: self-checking bench for the mode-dependent address decoder
// Assumes: default rom size, modes changed only between accesses
// Notes: each mode change waits for the three-stage strap synchroniser
module mad_decoder_tb;
	import mad_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [2:0] mode_pins_in = 3'h0;
	logic req_valid, ram_wr, ram_data, ext_wr, ext_data, ack, ram_en, ext_en;
	logic [23:0] req_addr;
	logic [2:0] area, mode;
	mad_target_type target;
	int err_count = 0;
	int checks_done = 0;

	always #50 clk_in = ~clk_in;

	mad_cpu_model cpu_u (.clk_in(clk_in), .req_valid_out(req_valid), .req_addr_out(req_addr),
		.ram_wr_out(ram_wr), .ram_data_out(ram_data), .ext_wr_out(ext_wr),
		.ext_data_out(ext_data));
	mad_decoder dut_u (.clk_in(clk_in), .rst_in(rst_in), .mode_pins_in(mode_pins_in),
		.req_valid_in(req_valid), .req_addr_in(req_addr), .ram_enable_wr_in(ram_wr),
		.ram_enable_data_in(ram_data), .ext_area_wr_in(ext_wr), .ext_area_data_in(ext_data),
		.ack_valid_out(ack), .target_out(target), .area_out(area), .mode_out(mode),
		.onchip_ram_enable_bit_out(ram_en), .external_area_extend_bit_out(ext_en));

	// ***************************************************
	// checking helpers
	// ***************************************************
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one access, answer looked at in the single cycle that it stands
	task automatic acc(input logic [23:0] a, input mad_target_type t, input logic [2:0] ar);
		cpu_u.access(a);
		#1;
		chk(24'(ack), 24'h000001);
		chk(24'(target), 24'(t));
		chk(24'(area), 24'(ar));
	endtask

	task automatic set_mode(input logic [2:0] m);
		@(posedge clk_in);
		mode_pins_in <= m;
		repeat (4) @(posedge clk_in);
		#1;
		chk(24'(mode), 24'(m));
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ***************************************************
	// scenarios
	// ***************************************************
	task automatic t_reset();
		chk(24'(ram_en), 24'h000001);
		chk(24'(ext_en), 24'h000000);
		chk(24'(ack), 24'h000000);
	endtask

	// normal modes: 64k space ignores the upper address bits, rom stops at 56k
	task automatic t_normal();
		// straps still at zero: no legal mode, so nothing is selected
		acc(24'h000000, MAD_TGT_NONE, 3'h0);
		set_mode(3'h1);
		acc(24'h000000, MAD_TGT_EXT, 3'h0);
		set_mode(3'h2);
		acc(24'h000000, MAD_TGT_ROM, 3'h0);
		acc(24'h00dfff, MAD_TGT_ROM, 3'h0);
		acc(24'h00e000, MAD_TGT_EXT, 3'h0);
		acc(24'he0ec00, MAD_TGT_RAM, 3'h0);
		acc(24'h00fc00, MAD_TGT_IO, 3'h0);
		acc(24'h00ff08, MAD_TGT_EXT, 3'h0);
		set_mode(3'h3);
		acc(24'h00e000, MAD_TGT_RSV, 3'h0);
		acc(24'h00ff28, MAD_TGT_IO, 3'h0);
	endtask

	// advanced expanded: eight areas, ram disable routes external
	task automatic t_adv_expanded();
		set_mode(3'h4);
		acc(24'ha00000, MAD_TGT_EXT, 3'h5);
		acc(24'hffec00, MAD_TGT_RAM, 3'h7);
		cpu_u.write_ctl(1'b0, 1'b0);
		// look after the edge that loads the bit, not in its own time step
		#1;
		chk(24'(ram_en), 24'h000000);
		acc(24'hffec00, MAD_TGT_EXT, 3'h7);
		cpu_u.write_ctl(1'b0, 1'b1);
		acc(24'hffec00, MAD_TGT_RAM, 3'h7);
		acc(24'hffff08, MAD_TGT_EXT, 3'h7);
		acc(24'hfffc00, MAD_TGT_IO, 3'h7);
		// mode 5: top of the ram range with ram off, then the first io word
		set_mode(3'h5);
		cpu_u.write_ctl(1'b0, 1'b0);
		acc(24'hfffbff, MAD_TGT_EXT, 3'h7);
		cpu_u.write_ctl(1'b0, 1'b1);
		acc(24'hfffc00, MAD_TGT_IO, 3'h7);
	endtask

	// second rom region follows the extension bit in modes 6 and 7
	task automatic t_second_rom();
		set_mode(3'h6);
		acc(24'h010000, MAD_TGT_ROM, 3'h0);
		cpu_u.write_ctl(1'b1, 1'b1);
		acc(24'h010000, MAD_TGT_EXT, 3'h0);
		acc(24'h01ffff, MAD_TGT_EXT, 3'h0);
		acc(24'h020000, MAD_TGT_EXT, 3'h0);
		acc(24'h3fffff, MAD_TGT_EXT, 3'h1);
		set_mode(3'h7);
		acc(24'h010000, MAD_TGT_RSV, 3'h0);
		acc(24'he00000, MAD_TGT_RSV, 3'h0);
		cpu_u.write_ctl(1'b0, 1'b0);
		acc(24'hffec00, MAD_TGT_RAM, 3'h0);
		cpu_u.write_ctl(1'b1, 1'b0);
		acc(24'h01ffff, MAD_TGT_ROM, 3'h0);
	endtask

	// ***************************************************
	// main sequence and watchdog
	// ***************************************************
	initial begin
		repeat (4) @(posedge clk_in);
		#1;
		t_reset();
		@(posedge clk_in);
		rst_in <= 1'b0;
		t_normal();
		t_adv_expanded();
		t_second_rom();
		final_report();
	end

	// the tests need about 110 cycles; this allows about eighteen times as many
	initial begin
		#200000;
		err_count++;
		final_report();
	end
endmodule
